// File: tb/dmie_exec_props.sv
// Port assertions for dmie_exec.
// Assumes one clock, sync active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dmie_exec_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Memory side
    input wire logic file_rd,
    input wire logic [6:0] file_rd_addr,
    input wire logic [7:0] file_rd_data,
    input wire logic file_wr,
    input wire logic [6:0] file_wr_addr,
    input wire logic [7:0] file_wr_data,
    input wire logic mem_rd,
    input wire logic mem_wr,
    // Results
    input wire logic [7:0] acc,
    input wire logic zero_flag,
    input wire logic done,
    input wire logic [15:0] pointer_reg1
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Fixed latency, no stall
    sequence s_fin;
        ##1 done;
    endsequence
    a_file_done: assert property (file_rd |-> s_fin)
        else $error("file read late");
    a_mem_done: assert property (mem_rd |-> s_fin)
        else $error("mem read late");
    a_done_pulse: assert property (done |=> !done)
        else $error("done too long");
    a_wb_data: assert property (file_wr |-> file_wr_data == $past(file_rd_data))
        else $error("write back data");
    a_wb_addr: assert property (file_wr |->
        $past(file_rd) && file_wr_addr == $past(file_rd_addr))
        else $error("write back addr");
    a_wb_keep: assert property (file_wr |-> $stable(acc))
        else $error("acc hit on write back");
    a_acc_cause: assert property ($changed(acc) |-> done)
        else $error("acc moved early");
    a_zero_wb: assert property (file_wr |-> zero_flag == (file_wr_data == 8'h00))
        else $error("zero flag on write back");
    a_zero_acc: assert property (done && !file_wr && !mem_wr |-> zero_flag == (acc == 8'h00))
        else $error("zero flag on acc");
    // Wrap comes for free in 16-bit compare
    a_ptr_step: assert property ($changed(pointer_reg1) |->
        pointer_reg1 == $past(pointer_reg1) + 16'h1 || pointer_reg1 == $past(pointer_reg1) - 16'h1)
        else $error("pointer step");
endmodule : dmie_exec_props
bind dmie_exec dmie_exec_props u_props (.clk, .rst, .file_rd, .file_rd_addr, .file_rd_data,
    .file_wr, .file_wr_addr, .file_wr_data, .mem_rd, .mem_wr, .acc, .zero_flag, .done,
    .pointer_reg1);
`default_nettype wire

// File: tb/test_data_move_indirect_exec.sv
// Bench for dmie_exec.
// Read data is held over a whole instruction.
`timescale 1ns/1ps
`default_nettype none
module test_data_move_indirect_exec;
    import dmie_pkg::*;
    logic clk, rst = 1, dm = 0, il = 0, ds = 0, ps = 0, rf = 0, sr, sm;
    logic frd, fwr, mrd, mwr, zf, dn;
    logic [6:0] fa = 0, fwa, fra;
    logic [1:0] cd = 0;
    logic [5:0] ofs = 0;
    logic [7:0] rdd = 0, fwd, mwd, acc, a0;
    logic [15:0] ma, mwa, p0, p1, e;
    logic [15:0] p [2] = '{16'h0, 16'h0};
    int n_errors = 0, num_checks = 0, cyc = 0, lat;
    dmie_exec u_dmie_exec (.clk, .rst, .direct_move_instr(dm), .indirect_load_instr(il),
        .file_addr(fa), .dest_sel(ds), .ptr_sel(ps), .rel_form(rf),
        .pointer_update_code(cd), .rel_offset(ofs), .file_rd(frd), .file_rd_addr(fra),
        .file_rd_data(rdd), .file_wr(fwr), .file_wr_addr(fwa), .file_wr_data(fwd),
        .mem_rd(mrd), .mem_addr(ma), .mem_rd_data(rdd), .mem_wr(mwr),
        .mem_wr_data_addr(mwa), .mem_wr_data(mwd), .acc, .zero_flag(zf), .done(dn),
        .pointer_reg0(p0), .pointer_reg1(p1));
    // 40 MHz clock
    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard, far above the run length
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    task chk(input logic [15:0] s, input logic [15:0] x);
        num_checks++;
        if (s !== x)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, s, x);
        end
    endtask : chk
    task print_verdict;
        if (n_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    // Issue one instruction, wait for done; strobes sampled off the edge
    task run(input logic m, input logic [7:0] d);
        dm <= m;
        il <= !m;
        rdd <= d;
        @(posedge clk);
        dm <= 0;
        il <= 0;
        #1;
        sr = frd;
        sm = mrd;
        for (lat = 1; lat < 9 && dn !== 1'b1; lat++)
        begin
            @(posedge clk);
            #1;
            sr |= frd;
            sm |= mrd;
        end
    endtask : run
    // Direct move; the two window addresses alias memory
    task t_dir(input logic [6:0] a, input logic d, input logic [7:0] v);
        logic w;
        w = (a == dmie_window0_addr) || (a == dmie_window1_addr);
        a0 = acc;
        @(posedge clk);
        fa <= a;
        ds <= d;
        run(1, v);
        chk(16'(lat), 16'(dmie_mem_lat + 1));
        chk(sr, !w);
        chk(sm, w);
        chk(fwr, d && !w);
        chk(mwr, d && w);
        chk(acc, d ? a0 : v);
        chk(zf, v == 8'h00);
        if (w)
            chk(d ? mwa : ma, p[a == dmie_window1_addr]);
        if (d)
            chk(w ? mwd : fwd, v);
        if (!w)
            chk(fra, a);
        if (d && !w)
            chk(fwa, a);
    endtask : t_dir
    // Indirect load, update or offset
    task t_ind(input logic s, input logic [1:0] c, input logic r, input logic [5:0] k,
        input logic [7:0] v);
        logic [15:0] o;
        o = p[s];
        p[s] = r ? o : (c[0] ? o - 16'h1 : o + 16'h1);
        e = r ? o + {{10{k[5]}}, k} : (c[1] ? o : p[s]);
        @(posedge clk);
        ps <= s;
        cd <= c;
        rf <= r;
        ofs <= k;
        run(0, v);
        chk(ma, e);
        chk(sm, 1'b1);
        chk(acc, v);
        chk(zf, v == 8'h00);
        chk(s ? p1 : p0, p[s]);
    endtask : t_ind
    // Reset between instructions returns strobes, done, acc, zero flag and both pointers to rest
    task t_rst;
        @(posedge clk);
        rst <= 1;
        repeat (3) @(posedge clk);
        rst <= 0;
        p[0] = dmie_ptr_rst;
        p[1] = dmie_ptr_rst;
        #1;
        chk(acc, dmie_acc_rst);
        chk(zf, 1'b0);
        chk(dn, 1'b0);
        chk({frd, mrd, fwr, mwr}, 4'h0);
        chk(p0, dmie_ptr_rst);
        chk(p1, dmie_ptr_rst);
    endtask : t_rst
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 0;
        t_dir(7'h7f, 0, 8'h00);
        t_dir(7'h05, 1, 8'h3c);
        for (int c = 0; c < 4; c++)
            t_ind(0, 2'(c), 0, 6'h00, 8'(c));
        t_ind(1, 2'h1, 0, 6'h00, 8'h55);
        t_ind(1, 2'h0, 0, 6'h00, 8'h66);
        t_ind(1, 2'h2, 1, 6'h20, 8'h77);
        t_ind(1, 2'h3, 1, 6'h1f, 8'h00);
        t_ind(1, 2'h2, 0, 6'h00, 8'h99);
        t_rst();
        t_ind(0, 2'h2, 0, 6'h00, 8'h10);
        t_dir(7'h01, 0, 8'h81);
        t_dir(7'h00, 1, 8'h00);
        t_dir(7'h01, 1, 8'h42);
        print_verdict();
    end
endmodule : test_data_move_indirect_exec
`default_nettype wire

// File: verilog/dmie_exec.sv
// Execution of the direct move and indirect load instructions.
// Assumes file registers and data memory answer a read one cycle after
// the strobe, and that the core holds a new instruction until done.
`timescale 1ns/1ps
`default_nettype none
module dmie_exec
    import dmie_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Instruction issue
    input wire logic direct_move_instr,
    input wire logic indirect_load_instr,
    input wire logic [6:0] file_addr,
    input wire logic dest_sel,
    input wire logic ptr_sel,
    input wire logic rel_form,
    input wire logic [1:0] pointer_update_code,
    input wire logic [5:0] rel_offset,
    // File register port
    output logic file_rd,
    output logic [6:0] file_rd_addr,
    input wire logic [7:0] file_rd_data,
    output logic file_wr,
    output logic [6:0] file_wr_addr,
    output logic [7:0] file_wr_data,
    // Data memory port
    output logic mem_rd,
    output logic [15:0] mem_addr,
    input wire logic [7:0] mem_rd_data,
    output logic mem_wr,
    output logic [15:0] mem_wr_data_addr,
    output logic [7:0] mem_wr_data,
    // Results
    output logic [7:0] acc,
    output logic zero_flag,
    output logic done,
    output logic [15:0] pointer_reg0,
    output logic [15:0] pointer_reg1
);
    // Issue state and operands captured at the take edge
    dmie_state_e state_q, state_d;
    logic is_direct_q;
    logic dest_q;
    logic via_mem_q;
    logic [6:0] faddr_q;
    logic [15:0] ea_q;

    // Registered port strobes and results
    logic file_rd_q;
    logic file_wr_q;
    logic mem_rd_q;
    logic mem_wr_q;
    logic done_q;
    logic [7:0] acc_q;
    logic [7:0] wr_data_q;
    logic zero_q;
    logic [15:0] ptr0_q;
    logic [15:0] ptr1_q;

    // Decode and arithmetic nets
    wire logic [15:0] ptr0;
    wire logic [15:0] ptr1;
    wire logic [15:0] ptr_cur;
    wire logic [15:0] ptr_inc;
    wire logic [15:0] ptr_dec;
    wire logic [15:0] ofs_ext;
    wire logic upd_is_dec;
    wire logic upd_is_pre;
    wire logic [15:0] ind_ea;
    wire logic [15:0] ptr_new;
    wire logic ptr_upd;
    wire logic start_dir;
    wire logic start_ind;
    wire logic dir_window;
    wire logic dir_win_sel;
    wire logic [7:0] rd_val;

    // Issue decode; new work only while idle
    assign start_dir = (state_q == dmie_idle_e) && direct_move_instr;
    assign start_ind = (state_q == dmie_idle_e) && indirect_load_instr && !direct_move_instr;

    // Pointer arithmetic, modulo 2^16 by plain truncation
    assign ptr_cur = ptr_sel ? ptr1 : ptr0;
    assign ptr_inc = 16'(ptr_cur + 16'h0001);
    assign ptr_dec = 16'(ptr_cur - 16'h0001);
    assign ofs_ext = {{10{rel_offset[5]}}, rel_offset};
    assign upd_is_dec = pointer_update_code[0];
    assign upd_is_pre = (pointer_update_code == dmie_upd_preinc)
        || (pointer_update_code == dmie_upd_predec);

    // Effective address of the indirect load
    assign ind_ea = rel_form ? 16'(ptr_cur + ofs_ext)
        : (upd_is_pre ? (upd_is_dec ? ptr_dec : ptr_inc) : ptr_cur);

    // Pointer moves at the take edge; offset form leaves it alone
    assign ptr_new = upd_is_dec ? ptr_dec : ptr_inc;
    assign ptr_upd = start_ind && !rel_form;

    // Direct move naming a window register goes to memory instead
    assign dir_window = (file_addr == dmie_window0_addr) || (file_addr == dmie_window1_addr);
    assign dir_win_sel = (file_addr == dmie_window1_addr);
    assign rd_val = via_mem_q ? mem_rd_data : file_rd_data;

    dmie_ptr_file u_ptrs (
        .clk(clk),
        .rst(rst),
        .wr_en(ptr_upd),
        .wr_sel(ptr_sel),
        .wr_val(ptr_new),
        .ptr0(ptr0),
        .ptr1(ptr1)
    );

    // Sequence: strobe read, capture data, report done
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            dmie_idle_e:
                if (start_dir || start_ind)
                    state_d = dmie_read_e;
            dmie_read_e:
                state_d = dmie_done_e;
            dmie_done_e:
                state_d = dmie_idle_e;
            default:
                state_d = dmie_idle_e;
        endcase
    end

    // Operand capture at issue
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= dmie_idle_e;
            is_direct_q <= 1'b0;
            dest_q <= 1'b0;
            via_mem_q <= 1'b0;
            faddr_q <= 7'h00;
            ea_q <= dmie_ptr_rst;
        end
        else
        begin
            state_q <= state_d;
            if (start_dir || start_ind)
            begin
                is_direct_q <= start_dir;
                dest_q <= dest_sel;
                faddr_q <= file_addr;
                via_mem_q <= start_ind || dir_window;
                // Window read on a direct move uses the pointer as address
                ea_q <= start_ind ? ind_ea : (dir_win_sel ? ptr1 : ptr0);
            end
        end
    end

    // Port strobes and results, all registered
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            file_rd_q <= 1'b0;
            mem_rd_q <= 1'b0;
            file_wr_q <= 1'b0;
            mem_wr_q <= 1'b0;
            done_q <= 1'b0;
            acc_q <= dmie_acc_rst;
            wr_data_q <= 8'h00;
            zero_q <= 1'b0;
            ptr0_q <= dmie_ptr_rst;
            ptr1_q <= dmie_ptr_rst;
        end
        else
        begin
            file_rd_q <= start_dir && !dir_window;
            mem_rd_q <= start_ind || (start_dir && dir_window);
            file_wr_q <= 1'b0;
            mem_wr_q <= 1'b0;
            done_q <= (state_q == dmie_read_e);
            ptr0_q <= ptr0;
            ptr1_q <= ptr1;
            if (state_q == dmie_read_e)
            begin
                zero_q <= (rd_val == 8'h00);
                if (is_direct_q && dest_q)
                begin
                    // Write back; window target writes memory, never a register
                    file_wr_q <= !via_mem_q;
                    mem_wr_q <= via_mem_q;
                    wr_data_q <= rd_val;
                end
                else
                    acc_q <= rd_val;
            end
        end
    end

    // Fixed latency, no wait states on either destination
    assign file_rd = file_rd_q;
    assign file_rd_addr = faddr_q;
    assign file_wr = file_wr_q;
    assign file_wr_addr = faddr_q;
    assign file_wr_data = wr_data_q;

    // Data memory port; address held from issue until the next take
    assign mem_rd = mem_rd_q;
    assign mem_addr = ea_q;
    assign mem_wr = mem_wr_q;
    assign mem_wr_data_addr = ea_q;
    assign mem_wr_data = wr_data_q;

    // Results and pointer copies, one cycle behind the pointer file
    assign acc = acc_q;
    assign zero_flag = zero_q;
    assign done = done_q;
    assign pointer_reg0 = ptr0_q;
    assign pointer_reg1 = ptr1_q;
endmodule : dmie_exec
`default_nettype wire

// File: verilog/dmie_pkg.sv
// Constants for the direct move / indirect load execution block.
// Assumes a core that presents one decoded instruction per instruction cycle.
// How it works
// - Direct move reads file register by 7-bit address
// - Destination bit zero: accumulator; one: same register
// - Direct move sets zero flag from moved value
// - Indirect load reads memory through selected pointer
// - Update code: pre-inc, pre-dec, post-inc, post-dec
// - Pre modes address pointer plus/minus one
// - Pointer ends old plus/minus one per mode
// - Offset form addresses pointer plus signed offset
// - Window registers alias pointer-addressed memory
// - Pointers are 16-bit and wrap around
// - Window registers hold no storage of their own
package dmie_pkg;
    localparam int dmie_data_w = 8;
    localparam int dmie_faddr_w = 7;
    localparam int dmie_ptr_w = 16;
    localparam int dmie_ofs_w = 6;
    // File addresses of the two indirect window registers
    localparam logic [6:0] dmie_window0_addr = 7'h00;
    localparam logic [6:0] dmie_window1_addr = 7'h01;
    // Pointer update codes
    localparam logic [1:0] dmie_upd_preinc = 2'h0;
    localparam logic [1:0] dmie_upd_predec = 2'h1;
    localparam logic [1:0] dmie_upd_postinc = 2'h2;
    localparam logic [1:0] dmie_upd_postdec = 2'h3;
    // Reset values
    localparam logic [15:0] dmie_ptr_rst = 16'h0000;
    localparam logic [7:0] dmie_acc_rst = 8'h00;
    // Read latency of the memory ports, in cycles
    localparam int dmie_mem_lat = 1;
    typedef enum logic [1:0] {
        dmie_idle_e = 2'b00,
        dmie_read_e = 2'b01,
        dmie_done_e = 2'b11
    } dmie_state_e;
endpackage : dmie_pkg

// File: verilog/dmie_ptr_file.sv
// Two 16-bit indirect pointers with one update port.
// Assumes a single updater on the core clock.
`timescale 1ns/1ps
`default_nettype none
module dmie_ptr_file
    import dmie_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Update port
    input wire logic wr_en,
    input wire logic wr_sel,
    input wire logic [15:0] wr_val,
    // Current values
    output logic [15:0] ptr0,
    output logic [15:0] ptr1
);
    logic [15:0] ptr_q [2];

    // One register per pointer
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_ptr
            always_ff @(posedge clk)
            begin
                if (rst)
                    ptr_q[gi] <= dmie_ptr_rst;
                else if (wr_en && (wr_sel == 1'(gi)))
                    ptr_q[gi] <= wr_val;
            end
        end
    endgenerate

    assign ptr0 = ptr_q[0];
    assign ptr1 = ptr_q[1];
endmodule : dmie_ptr_file
`default_nettype wire
